// *** src/pair_buffer.sv ***
// two-entry buffer with valid/ready on both sides
`timescale 1ns/100ps
module pair_buffer #(
	parameter int WIDTH = 8
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	rx_stream_if.snk fill,
	rx_stream_if.src drain
);
	logic [WIDTH-1:0] head_q;
	logic [WIDTH-1:0] tail_q;
	logic [1:0] count_q;
	wire push = fill.valid && fill.ready;
	wire pop = drain.valid && drain.ready;
	wire [1:0] count_after_pop = count_q - {1'b0, pop};

	assign fill.ready = (count_q != 2'h2);
	assign drain.valid = (count_q != 2'h0);
	assign drain.data = head_q;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			head_q <= '0;
			tail_q <= '0;
			count_q <= 2'h0;
		end
		else
		begin
			if (push && count_after_pop == 2'h0)
				head_q <= fill.data;
			else if (pop)
				head_q <= tail_q;
			if (push && count_after_pop != 2'h0)
				tail_q <= fill.data;
			count_q <= count_after_pop + {1'b0, push};
		end
	end
endmodule : pair_buffer

// *** src/rx_stream_if.sv ***
// valid/ready word channel into the receiver's buffer and out of it to the read path
`timescale 1ns/100ps
interface rx_stream_if #(parameter int WIDTH = 8);
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : rx_stream_if

// *** src/uart_addr_recognition_framing.sv ***
// serial port with framing check, four modes and address recognition
`timescale 1ns/100ps
module uart_addr_recognition_framing (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_bit_wr,
	input wire logic [2:0] sfr_bit_pos,
	input wire logic sfr_bit_val,
	input wire logic sfr_rd,
	output logic [7:0] sfr_rdata,
	input wire logic error_flag_select,
	input wire logic rate_doubler,
	input wire logic timer1_overflow,
	input wire logic timer2_overflow,
	input wire logic tx_rate_from_timer2,
	input wire logic rx_rate_from_timer2,
	input wire logic rxd_in,
	output logic rxd_out,
	output logic rxd_oe,
	output logic txd
);
	typedef enum logic [4:0] {
		RX_IDLE = 5'b0_0001,
		RX_START = 5'b0_0010,
		RX_DATA = 5'b0_0100,
		RX_STOP = 5'b0_1000,
		RX_SHIFT = 5'b1_0000
	} rx_state_t;
	typedef enum logic [2:0] {
		TX_IDLE = 3'b001,
		TX_FRAME = 3'b010,
		TX_SHIFT = 3'b100
	} tx_state_t;

	logic rst_s1_q;
	logic rst_n;
	logic rxd_s1_q;
	logic rxd_s2_q;
	logic rxd_prev_q;
	logic [7:0] ctrl_q;
	logic [7:0] ctrl_d;
	logic fe_q;
	logic [7:0] slave_address_q;
	logic [7:0] smask_q;
	logic [7:0] rdata_d;
	logic t1_half_q;
	logic [1:0] m2_cnt_q;
	logic [3:0] m0_cnt_q;
	rx_state_t rx_state_q;
	tx_state_t tx_state_q;
	logic [3:0] rx_os_q;
	logic [3:0] rx_bits_q;
	logic [8:0] rx_sh_q;
	logic [3:0] tx_os_q;
	logic [3:0] tx_bits_q;
	logic [10:0] tx_sh_q;
	logic tx_nine_q;
	logic txd_q;
	logic rxd_out_q;
	logic rxd_oe_q;

	// synchronise reset release and the serial input
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rst_s1_q <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_s1_q <= 1'b1;
			rst_n <= rst_s1_q;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rxd_s1_q <= 1'b1;
			rxd_s2_q <= 1'b1;
			rxd_prev_q <= 1'b1;
		end
		else
		begin
			rxd_s1_q <= rxd_in;
			rxd_s2_q <= rxd_s1_q;
			rxd_prev_q <= rxd_s2_q;
		end
	end

	// register decode
	wire mode_b0 = ctrl_q[uart_pkg::BIT_MODE0_OR_FE];
	wire mode_b1 = ctrl_q[uart_pkg::BIT_MODE1];
	wire [1:0] mode = {mode_b0, mode_b1};
	wire is_mode0 = (mode == uart_pkg::MODE_SHIFT);
	wire is_mode1 = (mode == uart_pkg::MODE_UART8);
	wire is_mode2 = (mode == uart_pkg::MODE_UART9_FIXED);
	wire is_nine = mode_b0;
	wire addr_filter = ctrl_q[uart_pkg::BIT_ADDR_FILTER];
	wire rx_enable = ctrl_q[uart_pkg::BIT_RX_ENABLE];
	wire tx_ninth = ctrl_q[uart_pkg::BIT_TX_NINTH];
	wire rx_done = ctrl_q[uart_pkg::BIT_RX_DONE];

	wire sel_ctrl = (sfr_addr == uart_pkg::ADDR_SERIAL_CONTROL);
	wire sel_buf = (sfr_addr == uart_pkg::ADDR_DATA_BUFFER);
	wire sel_slave_address = (sfr_addr == uart_pkg::ADDR_SLAVE_ADDRESS);
	wire sel_smask = (sfr_addr == uart_pkg::ADDR_SLAVE_ADDRESS_MASK);
	wire ctrl_byte_wr = sfr_wr && sel_ctrl;
	wire ctrl_bit_wr = sfr_bit_wr && sel_ctrl;
	wire buf_wr = sfr_wr && sel_buf;
	wire buf_rd = sfr_rd && sel_buf;
	wire [7:0] bit_onehot = 8'h01 << sfr_bit_pos;
	wire [7:0] wr_mask = ctrl_byte_wr ? 8'hFF :
		(ctrl_bit_wr ? bit_onehot : 8'h00);
	wire [7:0] wr_val = ctrl_byte_wr ? sfr_wdata : {8{sfr_bit_val}};
	// bit 7 goes to the error flag or the mode bit per the select input
	wire b7_wr = wr_mask[uart_pkg::BIT_MODE0_OR_FE];
	wire b7_val = wr_val[uart_pkg::BIT_MODE0_OR_FE];
	wire fe_wr = b7_wr && error_flag_select;
	wire m0_wr = b7_wr && !error_flag_select;

	// per-direction 16x tick: mode 2 from the clock, else timer overflows
	wire t1_tick = timer1_overflow && (rate_doubler || t1_half_q);
	// four clocks a tick, two when doubled: 64 or 32 clocks a bit
	wire [1:0] m2_last = rate_doubler ?
		2'(uart_pkg::MODE2_TICK_DIV / 2 - 1) :
		2'(uart_pkg::MODE2_TICK_DIV - 1);
	wire m2_tick = (m2_cnt_q == m2_last);
	wire tx_tick = is_mode2 ? m2_tick :
		(tx_rate_from_timer2 ? timer2_overflow : t1_tick);
	wire rx_tick = is_mode2 ? m2_tick :
		(rx_rate_from_timer2 ? timer2_overflow : t1_tick);
	wire m0_end = (m0_cnt_q == uart_pkg::M0_LAST);
	wire m0_mid = (m0_cnt_q == uart_pkg::M0_HALF);

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			t1_half_q <= 1'b0;
			m2_cnt_q <= 2'h0;
		end
		else
		begin
			if (timer1_overflow)
				t1_half_q <= !t1_half_q;
			m2_cnt_q <= m2_tick ? 2'h0 : m2_cnt_q + 2'h1;
		end
	end

	// address recognition
	wire [7:0] bcast = slave_address_q | smask_q;
	wire [7:0] rx_byte9 = rx_sh_q[7:0];
	wire [7:0] rx_byte8 = rx_sh_q[8:1];
	wire [7:0] rx_byte = (is_nine && !is_mode0) ? rx_byte9 : rx_byte8;
	wire given_hit = ((rx_byte & smask_q) == (slave_address_q & smask_q));
	wire bcast_hit = ((rx_byte & bcast) == bcast);
	wire addr_hit = given_hit || bcast_hit;
	wire stop_bit = rxd_s2_q;
	wire ninth_in = is_nine ? rx_sh_q[8] : stop_bit;
	// filter qualifies completion in modes 1..3 only
	wire accept9 = !addr_filter || (rx_sh_q[8] && addr_hit);
	wire accept8 = !addr_filter || (stop_bit && addr_hit);
	wire accept = is_nine ? accept9 : accept8;

	rx_stream_if #(.WIDTH(8)) push_s ();
	rx_stream_if #(.WIDTH(8)) pop_s ();

	// receiver
	wire rx_os_mid = rx_tick && (rx_os_q == uart_pkg::OS_MID);
	wire last_rx_bit = (rx_bits_q == (is_nine ? uart_pkg::DATA_BITS :
		uart_pkg::DATA_BITS - 4'h1));
	wire start_edge = rxd_prev_q && !rxd_s2_q;
	wire rx_go_uart = !is_mode0 && rx_enable && start_edge &&
		push_s.ready;
	wire rx_go_shift = is_mode0 && rx_enable && !rx_done &&
		push_s.ready && (tx_state_q == TX_IDLE);
	wire rx_stop_eval = (rx_state_q == RX_STOP) && rx_os_mid;
	wire rx_shift_done = (rx_state_q == RX_SHIFT) && m0_end &&
		(rx_bits_q == uart_pkg::DATA_BITS - 4'h1);
	wire rx_complete = (rx_stop_eval && accept) || rx_shift_done;
	wire frame_err = rx_stop_eval && !stop_bit;
	assign push_s.valid = rx_complete;
	assign push_s.data = rx_byte;
	assign pop_s.ready = buf_rd;

	pair_buffer #(.WIDTH(8)) rx_buf (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.fill(push_s),
		.drain(pop_s)
	);

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rx_state_q <= RX_IDLE;
			rx_os_q <= 4'h0;
			rx_bits_q <= 4'h0;
			rx_sh_q <= 9'h000;
		end
		else
		begin
			if (rx_tick)
				rx_os_q <= rx_os_q + 4'h1;
			case (rx_state_q)
				RX_IDLE:
				begin
					rx_bits_q <= 4'h0;
					if (rx_go_uart)
					begin
						rx_state_q <= RX_START;
						rx_os_q <= 4'h0;
					end
					else if (rx_go_shift)
						rx_state_q <= RX_SHIFT;
				end
				RX_START:
					if (rx_os_mid)
						rx_state_q <= rxd_s2_q ? RX_IDLE : RX_DATA;
				RX_DATA:
					if (rx_os_mid)
					begin
						rx_sh_q <= {rxd_s2_q, rx_sh_q[8:1]};
						rx_bits_q <= rx_bits_q + 4'h1;
						if (last_rx_bit)
							rx_state_q <= RX_STOP;
					end
				RX_STOP:
					if (rx_os_mid || !rx_enable)
						rx_state_q <= RX_IDLE;
				RX_SHIFT:
				begin
					if (m0_mid)
						rx_sh_q <= {rxd_s2_q, rx_sh_q[8:1]};
					if (m0_end)
						rx_bits_q <= rx_bits_q + 4'h1;
					if (rx_shift_done || !rx_enable)
						rx_state_q <= RX_IDLE;
				end
				default:
					rx_state_q <= RX_IDLE;
			endcase
		end
	end

	// transmitter; a write while busy is ignored
	wire tx_bit_end = tx_tick && (tx_os_q == uart_pkg::OS_LAST);
	wire [3:0] stop_idx = tx_nine_q ? uart_pkg::STOP_IDX_9 :
		uart_pkg::STOP_IDX_8;
	wire tx_start = buf_wr && (tx_state_q == TX_IDLE);
	wire tx_ti_uart = (tx_state_q == TX_FRAME) && tx_bit_end &&
		(tx_bits_q + 4'h1 == stop_idx);
	wire tx_ti_shift = (tx_state_q == TX_SHIFT) && m0_end &&
		(tx_bits_q == uart_pkg::DATA_BITS - 4'h1);
	wire tx_last_end = (tx_state_q == TX_FRAME) && tx_bit_end &&
		(tx_bits_q == stop_idx);
	wire ninth_out = is_nine ? tx_ninth : 1'b1;
	wire shifting = (rx_state_q == RX_SHIFT) || (tx_state_q == TX_SHIFT);

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_state_q <= TX_IDLE;
			tx_os_q <= 4'h0;
			tx_bits_q <= 4'h0;
			tx_sh_q <= 11'h7FF;
			tx_nine_q <= 1'b0;
		end
		else
		begin
			if (tx_tick)
				tx_os_q <= tx_os_q + 4'h1;
			case (tx_state_q)
				TX_IDLE:
				begin
					tx_bits_q <= 4'h0;
					tx_os_q <= 4'h0;
					if (tx_start)
					begin
						tx_sh_q <= {1'b1, ninth_out, sfr_wdata, 1'b0};
						tx_nine_q <= is_nine;
						tx_state_q <= is_mode0 ? TX_SHIFT : TX_FRAME;
						if (is_mode0)
							tx_sh_q <= {3'h7, sfr_wdata};
					end
				end
				TX_FRAME:
					if (tx_bit_end)
					begin
						tx_sh_q <= {1'b1, tx_sh_q[10:1]};
						tx_bits_q <= tx_bits_q + 4'h1;
						if (tx_last_end)
							tx_state_q <= TX_IDLE;
					end
				TX_SHIFT:
					if (m0_end)
					begin
						tx_sh_q <= {1'b1, tx_sh_q[10:1]};
						tx_bits_q <= tx_bits_q + 4'h1;
						if (tx_ti_shift)
							tx_state_q <= TX_IDLE;
					end
				default:
					tx_state_q <= TX_IDLE;
			endcase
		end
	end

	// mode 0 shift clock: low for the first half of each bit, high after
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			m0_cnt_q <= 4'h0;
		else if (!shifting || m0_end)
			m0_cnt_q <= 4'h0;
		else
			m0_cnt_q <= m0_cnt_q + 4'h1;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			txd_q <= 1'b1;
			rxd_out_q <= 1'b1;
			rxd_oe_q <= 1'b0;
		end
		else
		begin
			txd_q <= shifting ? (m0_cnt_q >= uart_pkg::M0_HALF) :
				tx_sh_q[0];
			rxd_out_q <= tx_sh_q[0];
			rxd_oe_q <= (tx_state_q == TX_SHIFT);
		end
	end
	assign txd = txd_q;
	assign rxd_out = rxd_out_q;
	assign rxd_oe = rxd_oe_q;

	// control register: hardware set or load wins over a software write
	always_comb
	begin
		ctrl_d = ctrl_q;
		for (int i = 0; i < 8; i++)
			if (wr_mask[i])
				ctrl_d[i] = wr_val[i];
		ctrl_d[uart_pkg::BIT_MODE0_OR_FE] = m0_wr ? b7_val : mode_b0;
		if (rx_complete && !is_mode0)
			ctrl_d[uart_pkg::BIT_RX_NINTH] = ninth_in;
		if (rx_complete)
			ctrl_d[uart_pkg::BIT_RX_DONE] = 1'b1;
		if (tx_ti_uart || tx_ti_shift)
			ctrl_d[uart_pkg::BIT_TX_DONE] = 1'b1;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl_q <= uart_pkg::RESET_SERIAL_CONTROL;
			fe_q <= 1'b0;
			slave_address_q <= uart_pkg::RESET_SLAVE_ADDRESS;
			smask_q <= uart_pkg::RESET_SLAVE_ADDRESS_MASK;
		end
		else
		begin
			ctrl_q <= ctrl_d;
			if (frame_err)
				fe_q <= 1'b1;
			else if (fe_wr)
				fe_q <= b7_val;
			if (sfr_wr && sel_slave_address)
				slave_address_q <= sfr_wdata;
			if (sfr_wr && sel_smask)
				smask_q <= sfr_wdata;
		end
	end

	// read path; unmapped addresses read zero
	wire [7:0] ctrl_view = {error_flag_select ? fe_q : mode_b0,
		ctrl_q[6:0]};
	assign rdata_d = sel_ctrl ? ctrl_view :
		sel_buf ? pop_s.data :
		sel_slave_address ? slave_address_q :
		sel_smask ? smask_q : 8'h00;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			sfr_rdata <= 8'h00;
		else if (sfr_rd)
			sfr_rdata <= rdata_d;
	end
endmodule : uart_addr_recognition_framing

// *** src/uart_pkg.sv ***
// constants shared by the serial port with address recognition
package uart_pkg;
	// special function register addresses
	localparam logic [7:0] ADDR_SERIAL_CONTROL = 8'h98;
	localparam logic [7:0] ADDR_DATA_BUFFER = 8'h99;
	localparam logic [7:0] ADDR_SLAVE_ADDRESS = 8'hA9;
	localparam logic [7:0] ADDR_SLAVE_ADDRESS_MASK = 8'hB9;
	localparam logic [7:0] RESET_SERIAL_CONTROL = 8'h00;
	localparam logic [7:0] RESET_SLAVE_ADDRESS = 8'h00;
	localparam logic [7:0] RESET_SLAVE_ADDRESS_MASK = 8'h00;
	// serial_control field positions
	localparam int BIT_MODE0_OR_FE = 7;
	localparam int BIT_MODE1 = 6;
	localparam int BIT_ADDR_FILTER = 5;
	localparam int BIT_RX_ENABLE = 4;
	localparam int BIT_TX_NINTH = 3;
	localparam int BIT_RX_NINTH = 2;
	localparam int BIT_TX_DONE = 1;
	localparam int BIT_RX_DONE = 0;
	// operating modes {mode_select_bit0, mode_select_bit1}
	typedef enum logic [1:0] {
		MODE_SHIFT = 2'h0,
		MODE_UART8 = 2'h1,
		MODE_UART9_FIXED = 2'h2,
		MODE_UART9_VAR = 2'h3
	} mode_t;
	// rate figures
	localparam int MODE0_DIVISOR = 12;
	localparam int MODE2_DIVISOR = 64;
	localparam int OVERSAMPLE = 16;
	localparam int MODE2_TICK_DIV = MODE2_DIVISOR / OVERSAMPLE;
	localparam int TIMER1_DIVISOR = 32;
	localparam int T1_OVF_PER_TICK = TIMER1_DIVISOR / OVERSAMPLE;
	localparam logic [3:0] OS_MID = 4'h7;
	localparam logic [3:0] OS_LAST = 4'hF;
	localparam logic [3:0] M0_HALF = 4'h6;
	localparam logic [3:0] M0_LAST = 4'hB;
	localparam logic [3:0] DATA_BITS = 4'h8;
	localparam logic [3:0] STOP_IDX_8 = 4'h9;
	localparam logic [3:0] STOP_IDX_9 = 4'hA;
endpackage : uart_pkg

// *** verification/uart_addr_recognition_framing_monitor.sv ***
// checker for the serial port register bus and shift clock
`timescale 1ns/100ps
module uart_addr_recognition_framing_monitor (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_bit_wr,
	input wire logic [2:0] sfr_bit_pos,
	input wire logic sfr_bit_val,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_rdata,
	input wire logic rxd_oe,
	input wire logic txd
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!arst_n);
	wire at_ctrl = sfr_addr == uart_pkg::ADDR_SERIAL_CONTROL;
	wire at_addr = sfr_addr == uart_pkg::ADDR_SLAVE_ADDRESS;
	wire at_mask = sfr_addr == uart_pkg::ADDR_SLAVE_ADDRESS_MASK;
	wire mapped = at_ctrl || at_addr || at_mask ||
		sfr_addr == uart_pkg::ADDR_DATA_BUFFER;
	wire quiet = !sfr_wr && !sfr_bit_wr;
	a_reset_idle: assert property ($rose(arst_n) |->
		txd && !rxd_oe && sfr_rdata == 8'h00)
		else $error("outputs not idle at reset release");
	a_unmapped_zero: assert property (sfr_rd && !mapped |=>
		sfr_rdata == 8'h00) else $error("unmapped read not zero");
	a_rdata_holds: assert property (!sfr_rd |=> $stable(sfr_rdata))
		else $error("read data moved without a read");
	a_addr_readback: assert property ((sfr_wr && at_addr) ##1 quiet
		##1 (sfr_rd && at_addr) |=> sfr_rdata == $past(sfr_wdata, 3))
		else $error("slave address readback wrong");
	a_mask_readback: assert property ((sfr_wr && at_mask) ##1 quiet
		##1 (sfr_rd && at_mask) |=> sfr_rdata == $past(sfr_wdata, 3))
		else $error("mask readback wrong");
	a_ctrl_readback: assert property ((sfr_wr && at_ctrl) ##1 quiet
		##1 (sfr_rd && at_ctrl) |=>
		sfr_rdata[6:3] == $past(sfr_wdata[6:3], 3))
		else $error("control software bits readback wrong");
	a_bit_write: assert property ((sfr_bit_wr && at_ctrl &&
		sfr_bit_pos inside {[3:6]}) ##1 quiet ##1 (sfr_rd && at_ctrl) |=>
		sfr_rdata[$past(sfr_bit_pos, 3)] == $past(sfr_bit_val, 3))
		else $error("control bit write not seen");
	a_shift_clock: assert property ($fell(txd) && rxd_oe |->
		(!txd)[*6] ##1 txd[*6]) else $error("shift clock not 6 low 6 high");
endmodule : uart_addr_recognition_framing_monitor
bind uart_addr_recognition_framing uart_addr_recognition_framing_monitor
	monitor_inst (.sys_clk(sys_clk), .arst_n(arst_n), .sfr_addr(sfr_addr),
	.sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_bit_wr(sfr_bit_wr),
	.sfr_bit_pos(sfr_bit_pos), .sfr_bit_val(sfr_bit_val), .sfr_rd(sfr_rd),
	.sfr_rdata(sfr_rdata), .rxd_oe(rxd_oe), .txd(txd));

// *** verification/uart_addr_recognition_framing_tb.sv ***
// self-checking bench for the serial port with address recognition
`timescale 1ns/100ps
module uart_addr_recognition_framing_tb;
	localparam logic [7:0] CTRL = uart_pkg::ADDR_SERIAL_CONTROL;
	localparam logic [7:0] DBUF = uart_pkg::ADDR_DATA_BUFFER;
	localparam logic [7:0] SADR = uart_pkg::ADDR_SLAVE_ADDRESS;
	localparam logic [7:0] SMSK = uart_pkg::ADDR_SLAVE_ADDRESS_MASK;
	logic sys_clk = 1'b0, arst_n = 1'b0, ovf = 1'b0;
	logic sfr_wr = 1'b0, sfr_bit_wr = 1'b0, sfr_bit_val = 1'b0;
	logic sfr_rd = 1'b0, error_flag_select = 1'b0, rate_doubler = 1'b0;
	logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00;
	logic [2:0] sfr_bit_pos = 3'h0;
	logic [7:0] sfr_rdata, rd, d, bc, slave_address, smask;
	logic rxd_out, rxd_oe, txd, node_line, filt, m9, ren, hit, acc;
	logic [9:0] g;
	logic [7:0] picks [4] = '{8'hF0, 8'hF7, 8'hFF, 8'hF5};
	int num_errors = 0;
	int compares = 0;
	int seed = 97;
	int rxq[$];
	wire rxd_in = rxd_oe ? rxd_out : node_line;
	always #2.5 sys_clk = ~sys_clk;
	// stand-in for a reload timer; its interrupt is never used
	always @(posedge sys_clk) ovf <= #1 ~ovf;
	uart_addr_recognition_framing uart_addr_recognition_framing_inst (
		.sys_clk(sys_clk), .arst_n(arst_n), .sfr_addr(sfr_addr),
		.sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_bit_wr(sfr_bit_wr),
		.sfr_bit_pos(sfr_bit_pos), .sfr_bit_val(sfr_bit_val),
		.sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
		.error_flag_select(error_flag_select), .rate_doubler(rate_doubler),
		.timer1_overflow(ovf), .timer2_overflow(ovf),
		.tx_rate_from_timer2(1'b0), .rx_rate_from_timer2(1'b1),
		.rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd));
	uart_node uart_node_inst (.sys_clk(sys_clk), .txd(txd), .rxd_oe(rxd_oe),
		.rxd_out(rxd_out), .line(node_line));
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : cyc
	task automatic chk(input string what, input logic [8:0] seen,
		input logic [8:0] exp);
		compares++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		sfr_addr = a;
		sfr_wdata = v;
		sfr_wr = 1'b1;
		cyc(1);
		sfr_wr = 1'b0;
		cyc(1);
	endtask : wr
	task automatic rdr(input logic [7:0] a);
		sfr_addr = a;
		sfr_rd = 1'b1;
		cyc(1);
		sfr_rd = 1'b0;
		rd = sfr_rdata;
		cyc(1);
	endtask : rdr
	task automatic bw(input logic [2:0] p, input logic v);
		sfr_addr = CTRL;
		sfr_bit_pos = p;
		sfr_bit_val = v;
		sfr_bit_wr = 1'b1;
		cyc(1);
		sfr_bit_wr = 1'b0;
		cyc(1);
	endtask : bw
	task automatic drain;
		while (rxq.size() > 0)
		begin
			rdr(DBUF);
			chk("rx_data", {1'b0, rd}, {1'b0, 8'(rxq.pop_front())});
		end
	endtask : drain
	task automatic frame_tx(input logic [1:0] m, input logic dbl);
		d = 8'($random(seed));
		rate_doubler = dbl;
		// receiver kept off in mode 0, where enabling it starts a shift-in
		wr(CTRL, {m, 1'b0, m != 2'b00, d[0], 3'b000});
		fork
			uart_node_inst.grab(m, dbl ? 32 : 64, g);
			wr(DBUF, d);
		join
		// let the stop bit finish: a buffer write while busy is dropped
		cyc(dbl ? 32 : 64);
		chk("tx_data", {1'b0, g[7:0]}, {1'b0, d});
		if (m[1])
			chk("tx_ninth", {8'h00, g[8]}, {8'h00, d[0]});
		if (m != 2'b00)
			chk("tx_stop", {8'h00, m[1] ? g[9] : g[8]}, 9'h001);
		rdr(CTRL);
		chk("tx_done", {8'h00, rd[1]}, 9'h001);
		bw(3'h1, 1'b0);
	endtask : frame_tx
	task automatic frame_rx(input logic [7:0] v, input logic n9,
		input logic stp);
		bc = slave_address | smask;
		hit = ((v ^ slave_address) & smask) == 8'h00;
		hit = hit || ((v ^ bc) & bc) == 8'h00;
		acc = ren && (!filt || (hit && (m9 ? n9 : stp)));
		uart_node_inst.send(m9, v, n9, stp);
		cyc(4);
		rdr(CTRL);
		chk("rx_done", {8'h00, rd[0]}, {8'h00, acc});
		if (acc)
		begin
			chk("rx_ninth", {8'h00, rd[2]}, {8'h00, m9 ? n9 : stp});
			rxq.push_back(v);
			bw(3'h0, 1'b0);
			drain();
		end
	endtask : frame_rx
	task automatic end_of_test;
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_of_test
	initial
	begin
		cyc(4);
		arst_n = 1'b1;
		cyc(3);
		for (int i = 0; i < 4; i++)
		begin
			rdr(i == 0 ? CTRL : i == 1 ? SADR : i == 2 ? SMSK : 8'h55);
			chk("reset_value", {1'b0, rd}, 9'h000);
		end
		for (int i = 0; i < 4; i++)
		begin
			d = 8'($random(seed));
			wr(i[0] ? SMSK : SADR, d);
			rdr(i[0] ? SMSK : SADR);
			chk("addr_regs", {1'b0, rd}, {1'b0, d});
		end
		wr(CTRL, 8'h68);
		bw(3'h4, 1'b1);
		rdr(CTRL);
		chk("ctrl", {1'b0, rd}, 9'h078);
		for (int i = 0; i < 8; i++)
			frame_tx(2'(i % 4), i >= 4);
		m9 = 1'b0;
		filt = 1'b0;
		ren = 1'b1;
		wr(CTRL, 8'h50);
		frame_rx(8'($random(seed)), 1'b0, 1'b1);
		frame_rx(8'h3C, 1'b0, 1'b0);
		error_flag_select = 1'b1;
		rdr(CTRL);
		chk("frame_err", {8'h00, rd[7]}, 9'h001);
		frame_rx(8'hC3, 1'b0, 1'b1);
		rdr(CTRL);
		chk("frame_err_held", {8'h00, rd[7]}, 9'h001);
		bw(3'h7, 1'b0);
		rdr(CTRL);
		chk("frame_err_clr", {8'h00, rd[7]}, 9'h000);
		error_flag_select = 1'b0;
		rdr(CTRL);
		chk("mode_bits", {7'h00, rd[7:6]}, 9'h001);
		// reader stalls: third frame must be refused, first two kept
		for (int i = 0; i < 3; i++)
			uart_node_inst.send(1'b0, 8'(8'h10 + i), 1'b0, 1'b1);
		rxq = '{8'h10, 8'h11};
		drain();
		bw(3'h0, 1'b0);
		ren = 1'b0;
		wr(CTRL, 8'h40);
		frame_rx(8'hA5, 1'b0, 1'b1);
		slave_address = 8'hF1;
		smask = 8'hFA;
		wr(SADR, slave_address);
		wr(SMSK, smask);
		ren = 1'b1;
		filt = 1'b1;
		for (int i = 0; i < 24; i++)
		begin
			if (i % 12 == 0)
			begin
				m9 = i > 0;
				wr(CTRL, m9 ? 8'hF0 : 8'h70);
			end
			d = i % 12 < 4 ? picks[i % 4] : 8'($random(seed));
			frame_rx(d, 1'($random(seed)), m9 | 1'($random(seed)));
		end
		// mode 0 shift-in of a random byte, node drives a bit per clock
		d = 8'($random(seed));
		fork
			uart_node_inst.feed(d);
			wr(CTRL, 8'h10);
		join
		cyc(12);
		rdr(CTRL);
		chk("rx_done_m0", {8'h00, rd[0]}, 9'h001);
		wr(CTRL, 8'h00);
		rdr(CTRL);
		chk("ctrl_clear", {1'b0, rd}, 9'h000);
		rxq.push_back(d);
		drain();
		end_of_test();
	end
	initial
	begin
		#300000;
		num_errors++;
		end_of_test();
	end
endmodule : uart_addr_recognition_framing_tb

// *** verification/uart_node.sv ***
// remote serial node: sends frames on the line, captures transmit frames
`timescale 1ns/100ps
module uart_node (
	input wire logic sys_clk,
	input wire logic txd,
	input wire logic rxd_oe,
	input wire logic rxd_out,
	output logic line
);
	// bench feeds the receiver from timer 2, giving 32 clocks a bit
	localparam int RX_BIT = 32;
	// idle mark between frames, as a pull-up would hold it
	initial line = 1'b1;
	task automatic send(input logic nine, input logic [7:0] d,
		input logic n9, input logic stp);
		logic [10:0] f;
		f = nine ? {stp, n9, d, 1'b0} : {1'b1, stp, d, 1'b0};
		for (int i = 0; i < (nine ? 11 : 10); i++)
		begin
			line = f[i];
			repeat (RX_BIT) @(posedge sys_clk);
			#1;
		end
		line = 1'b1;
	endtask : send
	task automatic grab(input logic [1:0] m, input int per,
		output logic [9:0] g);
		g = 10'h3FF;
		if (m == 2'b00)
			for (int i = 0; i < 8; i++)
			begin
				// data moves on the falling clock, so it is steady here
				@(posedge txd iff rxd_oe);
				#1;
				g[i] = rxd_out;
			end
		else
		begin
			@(negedge txd);
			repeat (per / 2) @(posedge sys_clk);
			for (int i = 0; i < (m[1] ? 10 : 9); i++)
			begin
				repeat (per) @(posedge sys_clk);
				g[i] = txd;
			end
		end
	endtask : grab
	// mode 0 shift-in: next bit goes out just after each rising shift clock
	task automatic feed(input logic [7:0] d);
		for (int i = 0; i < 8; i++)
		begin
			line = d[i];
			@(posedge txd);
			#1;
		end
		line = 1'b1;
	endtask : feed
endmodule : uart_node
